// [hw/sfd_map.svh]
/*
 * Frame codes, field positions, reset values and timing counts of the SPI
 * control frame decoder. Assumes a core clock with the period given below.
 */
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define SFD_FRAME_BITS      32
`define SFD_CMD_MSB         31
`define SFD_CMD_LSB         28
`define SFD_ACCESS_BIT      27
`define SFD_PARITY_BIT      0

// ----------------------------------------------------------------------------
// command codes and fixed patterns
// ----------------------------------------------------------------------------
`define SFD_CMD_GLOBAL      4'h0
`define SFD_CMD_CH1         4'h1
`define SFD_CMD_PULSE       4'h9
`define SFD_CMD_SELFTEST    4'ha
`define SFD_CMD_FIX_LOW     4'hb
`define SFD_CMD_FIX_HIGH    4'hd
`define SFD_FIX_FILL        28'haaaaaaa
`define SFD_PULSE_PATTERN   10'h155
`define SFD_SELFTEST_TAIL   2'h2
`define SFD_REQ_ON          2'h1
`define SFD_REQ_OFF         2'h2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SFD_RST_ACCESS      1'h1
`define SFD_RST_DEADTIME    2'h3
`define SFD_RST_TDIAG       2'h3
`define SFD_RST_THRESHOLD   6'h00
`define SFD_RST_CH1_FRAME   32'h1ec00001

// ----------------------------------------------------------------------------
// timing, times in microseconds, counts in core clock cycles
// ----------------------------------------------------------------------------
`define SFD_CLK_PERIOD_NS   100.0
`define SFD_US2CYC(t)       $rtoi((t) * 1000.0 / `SFD_CLK_PERIOD_NS + 0.5)
`define SFD_DEAD0_US        1.0
`define SFD_DEAD1_US        2.0
`define SFD_DEAD2_US        4.0
`define SFD_DEAD3_US        8.0
`define SFD_FLT_EXT0_US     11.2
`define SFD_FLT_EXT1_US     28.9
`define SFD_FLT_EXT2_US     40.0
`define SFD_FLT_EXT3_US     51.2
`define SFD_FLT_STD0_US     25.6
`define SFD_FLT_STD1_US     61.2
`define SFD_FLT_STD2_US     105.6
`define SFD_FLT_STD3_US     150.0

`endif

// [hw/sfd_pkg.sv]
/*
 * Types shared by the SPI control frame decoder.
 * Assumes sfd_map.svh carries all numeric constants.
 */
package sfd_pkg;
    typedef enum logic [0:0] {SFD_IDLE, SFD_SHIFT} sfd_state_t;
    typedef logic [31:0] sfd_frame_t;
endpackage

// [hw/sfd_sync.sv]
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are levels from outside the CLK domain.
 */
`timescale 1ns/1ps
`default_nettype none

module sfd_sync #(
    parameter int WIDTH = 1
) (
    input  wire  logic             CLK,
    input  wire  logic             RSTN,
    input  wire  logic [WIDTH-1:0] PIN_IN,
    input  wire  logic [WIDTH-1:0] RESET_LEVEL,
    output logic       [WIDTH-1:0] SYNC_OUT
);
    logic [WIDTH-1:0] meta_reg;

    // the first stage is read only by the second; both reset to the pin's
    // idle level so the edge detectors behind see no false edge on release
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            meta_reg <= RESET_LEVEL;
            SYNC_OUT <= RESET_LEVEL;
        end else begin
            meta_reg <= PIN_IN;
            SYNC_OUT <= meta_reg;
        end
    end
endmodule // sfd_sync

`default_nettype wire

// [hw/sfd_frame_decode.sv]
/*
 * SPI slave that decodes 32-bit command frames into channel control bits
 * and returns the response of the previous frame in the next one.
 * Assumes SPI mode 0 (SCK idle low, sample on rise, shift on fall), MSB
 * first, SCK slow enough (>= 4 CLK per half period) to be oversampled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfd_map.svh"

// What this block does
// [R1] code 1001 pulse frame, fixed pattern 0101010101
// [R2] bit 27 zero writes, one reads only
// [R3] bit 0 odd-parity bit, generated and checked
// [R4] bits 16:9 request OFF pulses ch8..1
// [R5] bits 8:1 request ON pulses ch8..1
// [R6] self-test starts only on field 01
// [R7] comm check 01 on, 10 off, else hold
// [R8] code 1010 frame, bits 2:1 equal 10
// [R9] commands 11..13 are fixed integrity frames
// [R10] bit 26 spread spectrum, resets off
// [R11] bit 25 diagnostics enable, resets off
// [R12] bits 24:17 pick pin or SPI control
// [R13] bits 16:9 hold channel actively off
// [R14] response 8:1 reports output voltage comparison
// [R15] status encoding follows HIGH_SIDE_CFG, also after reset
// [R16] response echoes command; access bit resets one
// [R17] bridge dead time 1/2/4/8 us, reset 11
// [R18] bit 24 shares channel-1 timer with 2..4
// [R19] filter time table depends on bridge mode
// [R20] bit 21 selects threshold readback kind
// [R21] six-bit overcurrent threshold, resets zero
// [R22] channel-1 frame reads 0x1EC00001 after reset
// [R23] bad parity or pattern frames are dropped
module sfd_frame_decode
    import sfd_pkg::*;
(
    input  wire  logic        CLK,
    input  wire  logic        RSTN,
    input  wire  logic        SPI_CS_N,
    input  wire  logic        SPI_SCK,
    input  wire  logic        SPI_SDI,
    output logic              SPI_SDO,
    output logic              SPI_SDO_OE_N,
    input  wire  logic [7:0]  CHANNEL_CONTROL_PIN_N,
    input  wire  logic [7:0]  VOUT_ABOVE_LVT,
    input  wire  logic [7:0]  VOUT_ABOVE_VOL,
    input  wire  logic [7:0]  HIGH_SIDE_CFG,
    input  wire  logic [7:0]  SPI_CHANNEL_ON,
    input  wire  logic        BRIDGE1_ENABLE,
    output logic [7:0]        CHANNEL_DRIVE,
    output logic [7:0]        ON_PULSE_REQUEST,
    output logic [7:0]        OFF_PULSE_REQUEST,
    output logic              SELFTEST_REQUEST,
    output logic              COMM_CHECK_ENABLE,
    output logic              SPREAD_SPECTRUM,
    output logic              DIAG_ENABLE,
    output logic [7:0]        CONTROL_SOURCE_SELECT,
    output logic [7:0]        CHANNEL_FORCE_OFF,
    output logic [1:0]        BRIDGE1_DEADTIME,
    output logic [6:0]        BRIDGE1_DEADTIME_CYCLES,
    output logic              BRIDGE1_TIMER_SHARE,
    output logic [1:0]        CH1_TDIAG,
    output logic [10:0]       CH1_FILTER_CYCLES,
    output logic              CH1_THRESHOLD_READBACK_SELECT,
    output logic [5:0]        CH1_OVERCURRENT_THRESHOLD,
    output logic              FRAME_ERROR
);
    // ------------------------------------------------------------------------
    // timing tables
    // ------------------------------------------------------------------------
    localparam logic [6:0]  DEAD_CYC [4] = '{7'(`SFD_US2CYC(`SFD_DEAD0_US)), 7'(`SFD_US2CYC(`SFD_DEAD1_US)),
                                             7'(`SFD_US2CYC(`SFD_DEAD2_US)), 7'(`SFD_US2CYC(`SFD_DEAD3_US))};
    localparam logic [10:0] FLT_EXT  [4] = '{11'(`SFD_US2CYC(`SFD_FLT_EXT0_US)), 11'(`SFD_US2CYC(`SFD_FLT_EXT1_US)),
                                             11'(`SFD_US2CYC(`SFD_FLT_EXT2_US)), 11'(`SFD_US2CYC(`SFD_FLT_EXT3_US))};
    localparam logic [10:0] FLT_STD  [4] = '{11'(`SFD_US2CYC(`SFD_FLT_STD0_US)), 11'(`SFD_US2CYC(`SFD_FLT_STD1_US)),
                                             11'(`SFD_US2CYC(`SFD_FLT_STD2_US)), 11'(`SFD_US2CYC(`SFD_FLT_STD3_US))};

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [2:0]  spi_s;
    logic [15:0] ana_s;
    logic        sck_d_reg;
    logic        cs_d_reg;

    sfd_sync #(.WIDTH(3)) u_spi_sync (
        .CLK        (CLK),
        .RSTN       (RSTN),
        .PIN_IN     ({SPI_CS_N, SPI_SCK, SPI_SDI}),
        .RESET_LEVEL(3'h4),
        .SYNC_OUT   (spi_s)
    );
    sfd_sync #(.WIDTH(16)) u_pin_sync (
        .CLK        (CLK),
        .RSTN       (RSTN),
        .PIN_IN     ({CHANNEL_CONTROL_PIN_N, VOUT_ABOVE_LVT}),
        .RESET_LEVEL(16'hff00),
        .SYNC_OUT   (ana_s)
    );

    wire cs_n_s   = spi_s[2];
    wire sck_rise = spi_s[1] & ~sck_d_reg;
    wire sck_fall = ~spi_s[1] & sck_d_reg;
    wire cs_fall  = ~cs_n_s & cs_d_reg;
    wire cs_rise  = cs_n_s & ~cs_d_reg;

    // the high-side comparator passes the same two stages
    logic [7:0] vol_m_reg;
    logic [7:0] vol_s_reg;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    sfd_state_t state_reg;
    sfd_frame_t rx_reg;
    sfd_frame_t tx_reg;
    sfd_frame_t echo_reg;
    logic [5:0] bit_cnt_reg;
    logic [3:0] resp_sel_reg;
    logic       glob_rw_reg;
    logic       ch1_rw_reg;

    // ------------------------------------------------------------------------
    // frame checks
    // ------------------------------------------------------------------------
    wire [3:0] rx_cmd     = rx_reg[`SFD_CMD_MSB:`SFD_CMD_LSB];
    wire       rx_write   = ~rx_reg[`SFD_ACCESS_BIT];                                       // [R2]
    wire       len_ok     = bit_cnt_reg == 6'(`SFD_FRAME_BITS);
    wire       parity_ok  = rx_reg[`SFD_PARITY_BIT] == ~^rx_reg[31:1];                      // [R3]
    wire       is_fixed   = rx_cmd >= `SFD_CMD_FIX_LOW && rx_cmd <= `SFD_CMD_FIX_HIGH;
    wire       fixed_ok   = rx_reg[27:0] == `SFD_FIX_FILL;                                  // [R9]
    wire       pulse_ok   = rx_reg[26:17] == `SFD_PULSE_PATTERN;                            // [R1]
    wire       stest_ok   = rx_reg[2:1] == `SFD_SELFTEST_TAIL;                              // [R8]
    wire       pattern_ok = (rx_cmd == `SFD_CMD_PULSE) ? pulse_ok :
                            (rx_cmd == `SFD_CMD_SELFTEST) ? stest_ok : 1'b1;
    wire       frame_end  = cs_rise && state_reg == SFD_SHIFT;
    wire       frame_ok   = len_ok && (is_fixed ? fixed_ok : (parity_ok && pattern_ok));   // [R23]
    wire       accept     = frame_end && frame_ok;
    wire       accept_wr  = accept && rx_write && !is_fixed;
    wire       wr_global  = accept_wr && rx_cmd == `SFD_CMD_GLOBAL;
    wire       wr_ch1     = accept_wr && rx_cmd == `SFD_CMD_CH1;
    wire       wr_pulse   = accept_wr && rx_cmd == `SFD_CMD_PULSE;
    wire       wr_stest   = accept_wr && rx_cmd == `SFD_CMD_SELFTEST;
    wire [1:0] stest_req  = rx_reg[6:5];
    wire [1:0] cc_req     = rx_reg[4:3];

    // ------------------------------------------------------------------------
    // response frames
    // ------------------------------------------------------------------------
    // status bit keeps each channel's own encoding from HIGH_SIDE_CFG, also after reset
    wire [7:0]  vout_stat = (HIGH_SIDE_CFG & vol_s_reg) | (~HIGH_SIDE_CFG & ana_s[7:0]);  // [R14] [R15]
    wire [30:0] glob_body = {`SFD_CMD_GLOBAL, glob_rw_reg, SPREAD_SPECTRUM, DIAG_ENABLE,
                             CONTROL_SOURCE_SELECT, CHANNEL_FORCE_OFF, vout_stat};       // [R16]
    wire [30:0] ch1_body  = {`SFD_CMD_CH1, ch1_rw_reg, BRIDGE1_DEADTIME, BRIDGE1_TIMER_SHARE,
                             CH1_TDIAG, CH1_THRESHOLD_READBACK_SELECT, CH1_OVERCURRENT_THRESHOLD,
                             14'h0000};
    wire sfd_frame_t glob_resp = {glob_body, ~^glob_body};                                  // [R3]
    wire sfd_frame_t ch1_resp  = {ch1_body, ~^ch1_body};                                    // [R22]
    wire sfd_frame_t resp      = (resp_sel_reg == `SFD_CMD_GLOBAL) ? glob_resp :
                                 (resp_sel_reg == `SFD_CMD_CH1) ? ch1_resp : echo_reg;

    // ------------------------------------------------------------------------
    // configuration views and channel drive
    // ------------------------------------------------------------------------
    wire       ext_mode   = BRIDGE1_ENABLE & ~BRIDGE1_TIMER_SHARE;                          // [R18]
    wire [7:0] src_level  = (CONTROL_SOURCE_SELECT & SPI_CHANNEL_ON)
                          | (~CONTROL_SOURCE_SELECT & ~ana_s[15:8]);                        // [R12]
    wire [7:0] drive_next = src_level & ~CHANNEL_FORCE_OFF;                                 // [R13]

    // ------------------------------------------------------------------------
    // link edge tracking and shifting
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sck_d_reg <= 1'b0;
            cs_d_reg  <= 1'b1;
            vol_m_reg <= 8'h00;
            vol_s_reg <= 8'h00;
        end else begin
            sck_d_reg <= spi_s[1];
            cs_d_reg  <= cs_n_s;
            vol_m_reg <= VOUT_ABOVE_VOL;
            vol_s_reg <= vol_m_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_reg    <= SFD_IDLE;
            rx_reg       <= 32'h00000000;
            tx_reg       <= 32'h00000000;
            bit_cnt_reg  <= 6'h00;
            SPI_SDO      <= 1'b0;
            SPI_SDO_OE_N <= 1'b1;
        end else begin
            SPI_SDO_OE_N <= cs_n_s;
            case (state_reg)
                SFD_IDLE: begin
                    if (cs_fall) begin
                        state_reg   <= SFD_SHIFT;
                        tx_reg      <= resp;
                        SPI_SDO     <= resp[31];
                        bit_cnt_reg <= 6'h00;
                    end
                end
                SFD_SHIFT: begin
                    if (cs_n_s) begin
                        state_reg <= SFD_IDLE;
                    end else if (sck_rise) begin
                        rx_reg <= {rx_reg[30:0], spi_s[0]};
                        if (bit_cnt_reg != 6'h3f) begin
                            bit_cnt_reg <= bit_cnt_reg + 6'h01;
                        end
                    end else if (sck_fall) begin
                        tx_reg  <= {tx_reg[30:0], 1'b0};
                        SPI_SDO <= tx_reg[30];
                    end
                end
                default: state_reg <= SFD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // frame bookkeeping
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            resp_sel_reg <= `SFD_CMD_GLOBAL;
            echo_reg     <= 32'h00000000;
            glob_rw_reg  <= `SFD_RST_ACCESS;                                                // [R16]
            ch1_rw_reg   <= `SFD_RST_ACCESS;
            FRAME_ERROR  <= 1'b0;
        end else begin
            FRAME_ERROR <= frame_end && !frame_ok;                                          // [R23]
            if (accept) begin
                resp_sel_reg <= rx_cmd;
                echo_reg     <= rx_reg;
                if (rx_cmd == `SFD_CMD_GLOBAL) begin
                    glob_rw_reg <= rx_reg[`SFD_ACCESS_BIT];
                end
                if (rx_cmd == `SFD_CMD_CH1) begin
                    ch1_rw_reg <= rx_reg[`SFD_ACCESS_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // command effects
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ON_PULSE_REQUEST  <= 8'h00;
            OFF_PULSE_REQUEST <= 8'h00;
            SELFTEST_REQUEST  <= 1'b0;
            COMM_CHECK_ENABLE <= 1'b0;
        end else begin
            OFF_PULSE_REQUEST <= wr_pulse ? rx_reg[16:9] : 8'h00;                          // [R4]
            ON_PULSE_REQUEST  <= wr_pulse ? rx_reg[8:1] : 8'h00;                           // [R5]
            SELFTEST_REQUEST  <= wr_stest && stest_req == `SFD_REQ_ON;                      // [R6]
            if (wr_stest && cc_req == `SFD_REQ_ON) begin                                   // [R7]
                COMM_CHECK_ENABLE <= 1'b1;
            end else if (wr_stest && cc_req == `SFD_REQ_OFF) begin
                COMM_CHECK_ENABLE <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SPREAD_SPECTRUM       <= 1'b0;                                                  // [R10]
            DIAG_ENABLE           <= 1'b0;                                                  // [R11]
            CONTROL_SOURCE_SELECT <= 8'h00;
            CHANNEL_FORCE_OFF     <= 8'h00;
            CHANNEL_DRIVE         <= 8'h00;
        end else begin
            CHANNEL_DRIVE <= drive_next;
            if (wr_global) begin
                SPREAD_SPECTRUM       <= rx_reg[26];                                        // [R10]
                DIAG_ENABLE           <= rx_reg[25];                                        // [R11]
                CONTROL_SOURCE_SELECT <= rx_reg[24:17];                                     // [R12]
                CHANNEL_FORCE_OFF     <= rx_reg[16:9];                                      // [R13]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            BRIDGE1_DEADTIME              <= `SFD_RST_DEADTIME;                             // [R17]
            BRIDGE1_TIMER_SHARE           <= 1'b0;
            CH1_TDIAG                     <= `SFD_RST_TDIAG;
            CH1_THRESHOLD_READBACK_SELECT <= 1'b0;
            CH1_OVERCURRENT_THRESHOLD     <= `SFD_RST_THRESHOLD;                            // [R21]
            BRIDGE1_DEADTIME_CYCLES       <= 7'h00;
            CH1_FILTER_CYCLES             <= 11'h000;
        end else begin
            BRIDGE1_DEADTIME_CYCLES <= DEAD_CYC[BRIDGE1_DEADTIME];                          // [R17]
            CH1_FILTER_CYCLES       <= ext_mode ? FLT_EXT[CH1_TDIAG] : FLT_STD[CH1_TDIAG];  // [R19]
            if (wr_ch1) begin
                BRIDGE1_DEADTIME              <= rx_reg[26:25];
                BRIDGE1_TIMER_SHARE           <= rx_reg[24];                                // [R18]
                CH1_TDIAG                     <= rx_reg[23:22];
                CH1_THRESHOLD_READBACK_SELECT <= rx_reg[21];                                // [R20]
                CH1_OVERCURRENT_THRESHOLD     <= rx_reg[20:15];
            end
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_parity_drop:    assert property (frame_end && len_ok && !is_fixed && !parity_ok |=> FRAME_ERROR)  // [R3]
        else $error("bad parity frame not flagged");
    a_pattern_drop:   assert property (frame_end && rx_cmd == `SFD_CMD_PULSE && !pulse_ok
                                       |=> FRAME_ERROR && OFF_PULSE_REQUEST == 8'h00)  // [R1]
        else $error("pulse frame with wrong pattern acted on");
    a_read_only:      assert property (accept && !rx_write |=> $stable(CONTROL_SOURCE_SELECT)
                                       && $stable(CH1_OVERCURRENT_THRESHOLD))  // [R2]
        else $error("read-only frame changed configuration");
    a_off_pulse_src:  assert property (OFF_PULSE_REQUEST != 8'h00 |-> $past(wr_pulse))  // [R4]
        else $error("off pulse without pulse frame");
    a_on_pulse_once:  assert property (ON_PULSE_REQUEST != 8'h00 |=> ON_PULSE_REQUEST == 8'h00)  // [R5]
        else $error("on pulse request longer than one cycle");
    a_selftest_code:  assert property (SELFTEST_REQUEST |-> $past(stest_req) == `SFD_REQ_ON)  // [R6]
        else $error("self-test started on wrong code");
    a_cc_hold:        assert property (wr_stest && (cc_req == 2'h0 || cc_req == 2'h3)
                                       |=> $stable(COMM_CHECK_ENABLE))  // [R7]
        else $error("illegal comm-check code changed enable");
    a_force_off:      assert property ((CHANNEL_DRIVE & $past(CHANNEL_FORCE_OFF)) == 8'h00)  // [R13]
        else $error("forced-off channel driven");
    a_ch1_reset:      assert property ($past(!RSTN) |-> ch1_resp == `SFD_RST_CH1_FRAME)  // [R22]
        else $error("channel-1 frame wrong after reset");
    a_sdo_enable:     assert property (!state_reg[0] && cs_n_s |=> SPI_SDO_OE_N)
        else $error("sdo driven while deselected");

    c_global_write:   cover property (wr_global);
    c_ch1_read:       cover property (accept && rx_cmd == `SFD_CMD_CH1 && !rx_write);
    c_selftest:       cover property (SELFTEST_REQUEST);
    c_fixed_frame:    cover property (accept && is_fixed);
endmodule // sfd_frame_decode

`default_nettype wire

// [test/sfd_host_model.sv]
/* host SPI master model for the frame decoder.
   assumes mode 0, MSB first, a 10 MHz core clock and an 800 ns link clock. */
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
    input  wire logic CLK,
    input  wire logic SDO,
    output logic      SCK,
    output logic      CS_N,
    output logic      SDI
);
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SDI = 1'b0;
    end
    // sck stands low between frames; sdo is sampled mid high phase, clear of its shift
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        @(posedge CLK);
        CS_N <= 1'b0;
        repeat (8) @(posedge CLK);
        for (int i = 31; i >= 0; i--) begin
            SDI <= tx[i];
            repeat (4) @(posedge CLK);
            SCK <= 1'b1;
            repeat (2) @(posedge CLK);
            rx[i] = SDO;
            repeat (2) @(posedge CLK);
            SCK <= 1'b0;
        end
        repeat (4) @(posedge CLK);
        CS_N <= 1'b1;
        SDI <= ~tx[0];
        repeat (8) @(posedge CLK);
    endtask
endmodule // sfd_host_model
`default_nettype wire

// [test/sfd_frame_decode_tb.sv]
/* self-checking bench: frames go through the host model.
   assumes the response to each frame returns during the next one. */
`timescale 1ns/1ps
`default_nettype none
module sfd_frame_decode_tb;
    localparam logic [8:0] ST_TAB [5] = '{9'h0b3, 9'h071, 9'h191, 9'h150, 9'h0ac};
    logic clk, rstn, sck, cs_n, sdi, sdo, oe_n, err, st, cc, ss, dg, sh, rd, br, clr;
    logic [7:0]  pin_n, lowside_voltage_threshold, highside_voltage_threshold, hs, spi_on, drv, onp, offp, src, fo;
    logic [1:0]  dt, td;
    logic [6:0]  dtc;
    logic [10:0] fc;
    logic [5:0]  thr;
    logic [17:0] seen;
    int          miscompares = 0;
    int          n_compared = 0;
    sfd_host_model host_u (.CLK(clk), .SDO(sdo), .SCK(sck), .CS_N(cs_n), .SDI(sdi));
    sfd_frame_decode dut_u (.CLK(clk), .RSTN(rstn), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SDI(sdi),
        .SPI_SDO(sdo), .SPI_SDO_OE_N(oe_n), .CHANNEL_CONTROL_PIN_N(pin_n), .VOUT_ABOVE_LVT(lowside_voltage_threshold),
        .VOUT_ABOVE_VOL(highside_voltage_threshold), .HIGH_SIDE_CFG(hs), .SPI_CHANNEL_ON(spi_on), .BRIDGE1_ENABLE(br),
        .CHANNEL_DRIVE(drv), .ON_PULSE_REQUEST(onp), .OFF_PULSE_REQUEST(offp), .SELFTEST_REQUEST(st),
        .COMM_CHECK_ENABLE(cc), .SPREAD_SPECTRUM(ss), .DIAG_ENABLE(dg), .CONTROL_SOURCE_SELECT(src),
        .CHANNEL_FORCE_OFF(fo), .BRIDGE1_DEADTIME(dt), .BRIDGE1_DEADTIME_CYCLES(dtc),
        .BRIDGE1_TIMER_SHARE(sh), .CH1_TDIAG(td), .CH1_FILTER_CYCLES(fc),
        .CH1_THRESHOLD_READBACK_SELECT(rd), .CH1_OVERCURRENT_THRESHOLD(thr), .FRAME_ERROR(err));
    // one-cycle pulses are gathered so a whole frame can be judged at once
    always @(posedge clk) seen <= clr ? 18'h0 : seen | {err, st, offp, onp};
    function automatic logic [31:0] par(input logic [31:1] b);
        return {b, ~^b};
    endfunction
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [31:0] tx, input logic [31:0] exp);
        logic [31:0] rx;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        host_u.xfer(tx, rx);
        cmp(rx, exp);
    endtask
    // reset with the pulse gatherer cleared, so a false frame on release shows up
    task automatic reset_check();
        {rstn, clr} <= 2'b01;
        repeat (3) @(posedge clk);
        {rstn, clr} <= 2'b10;
        repeat (6) @(posedge clk);
        cmp({oe_n, drv, seen, ss, dg, src, fo, dt, sh, td, rd, thr}, {1'b1, 8'h8f, 36'h0, 12'hd80});
    endtask
    task automatic give_verdict();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2000000;
        miscompares++;
        give_verdict();
    end
    initial begin
        logic [31:0] g, c;
        {hs, br} = {8'h00, 1'b1};
        {pin_n, lowside_voltage_threshold, highside_voltage_threshold, spi_on} = {8'h70, 8'h3c, 8'hc3, 8'hab};
        reset_check();
        frame(par({4'h1, 1'b1, 26'h0}), par({4'h0, 1'b1, 18'h0, 8'h3c}));
        frame(par({4'h0, 1'b0, 2'b11, 8'h0f, 8'h81, 8'h00}), 32'h1ec00001);
        cmp({ss, dg, src, fo, drv}, {2'b11, 8'h0f, 8'h81, 8'h0a});
        hs <= 8'h0f;
        g = par({4'h0, 1'b0, 2'b11, 8'h0f, 8'h81, 8'h33});
        frame(par({4'h0, 1'b0, 26'h0}) ^ 32'h1, g);
        cmp({seen[17], ss, dg, src, fo}, {3'b111, 8'h0f, 8'h81});
        frame(par({4'h9, 1'b0, 10'h155, 8'ha5, 8'h5a}), g);
        cmp(seen, {2'b00, 8'ha5, 8'h5a});
        c = par({4'h9, 1'b0, 10'h155, 8'ha5, 8'h5a});
        frame(par({4'h9, 1'b0, 10'h154, 8'ha5, 8'h5a}), c);
        cmp(seen, 18'h20000);
        for (int i = 0; i < 5; i++) begin
            g = par({4'ha, 1'b0, 20'h0, ST_TAB[i][8:3]});
            frame(g, c);
            cmp({seen[17:16], cc}, ST_TAB[i][2:0]);
            if (!ST_TAB[i][2]) c = g;
        end
        for (int i = 0; i < 4; i++) begin
            g = {4'hb + 4'(i % 3), 28'haaaaaaa} ^ {31'h0, i == 3};
            frame(g, c);
            cmp(seen[17], i == 3);
            if (i < 3) c = g;
        end
        g = par({4'h1, 1'b0, 2'b01, 1'b1, 2'b10, 1'b1, 6'h2a, 14'h0});
        frame(g, c);
        cmp({dt, sh, td, rd, thr, dtc, fc}, {12'h76a, 7'h14, 11'h420});
        frame(par({4'h1, 1'b1, 2'b11, 1'b0, 2'b00, 1'b0, 6'h3f, 14'h0}), g);
        cmp({dt, sh, td, rd, thr}, 12'h76a);
        g[27] = 1'b1;
        g[0] = ~g[0];
        frame(par({4'h1, 1'b0, 2'b11, 1'b0, 2'b00, 1'b0, 6'h00, 14'h0}), g);
        cmp({dt, dtc, fc}, {2'b11, 7'h50, 11'h070});
        reset_check();
        frame(par({4'h1, 1'b1, 26'h0}), par({4'h0, 1'b1, 18'h0, 8'h33}));
        frame(par({4'h1, 1'b1, 26'h0}), 32'h1ec00001);
        give_verdict();
    end
endmodule // sfd_frame_decode_tb
`default_nettype wire
